// file: rtl/rfp_params.svh
// What this block does
// - Fractional divider yields 32768 ticks per second
// - 13-bit integer and 15-bit fraction counters
// - Integer register bits 12:0, reset zero, RW
// - Fraction register bits 14:0, reset zero, RW
// - Tick lasts integer+1 clocks, stretched one more
// - Combinational logic decides each cycle's stretch
// - Fraction bit 14 stretches odd fraction counts
// - Bit k matches lowest set bit 14-k
// - Zero fraction gives equal ticks, else even spread
// - Time advances only while clock runs
// - Seconds count 0..59, wrap enables minutes
`ifndef RFP_PARAMS_SVH
`define RFP_PARAMS_SVH

// ****************************************
// Register map and fields
// ****************************************
`define RFP_ADDR_W          32
`define RFP_OFF_INT         32'he0024080
`define RFP_OFF_FRAC        32'he0024084
`define RFP_INT_W           13
`define RFP_FRAC_W          15
`define RFP_INT_RST         13'h0000
`define RFP_FRAC_RST        15'h0000

// ****************************************
// Counting constants
// ****************************************
`define RFP_TICKS_PER_SEC   32768
`define RFP_TICK_CNT_W      15
`define RFP_SEC_W           6
`define RFP_SEC_MAX         6'h3b

`endif

// file: rtl/rfp_pkg.sv
// ****************************************
// Shared types
// ****************************************
package rfp_pkg;
    // Divider phase: counting down or in the stretch clock
    typedef enum logic [0:0]
    {
        RFP_COUNT   = 1'b0,
        RFP_STRETCH = 1'b1
    } rfp_phase_type;
endpackage : rfp_pkg

// file: rtl/rfp_prescaler.sv
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`include "rfp_params.svh"
// ****************************************
// Fractional RTC prescaler top
// ****************************************
module rfp_prescaler
    import rfp_pkg::*;
#(
    parameter int INT_W  = `RFP_INT_W,
    parameter int FRAC_W = `RFP_FRAC_W
)
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    // Register port
    input  wire logic [`RFP_ADDR_W-1:0]   reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [31:0]              reg_rdata,
    // Time keeping outputs
    output logic                          ref_tick,
    output logic                          sec_tick,
    output logic [`RFP_TICK_CNT_W-1:0]    tick_count_q,
    output logic [`RFP_SEC_W-1:0]         seconds,
    output logic                          min_en
);
    // ****************************************
    // Registers
    // ****************************************
    logic [INT_W-1:0]  prescale_integer_q;   // Integer prescale
    logic [FRAC_W-1:0] prescale_fraction_q;  // Fraction prescale
    logic [INT_W-1:0]  int_count_q;          // Integer down-counter
    logic [FRAC_W-1:0] frac_count_q;         // Fraction counter
    rfp_phase_type     phase_q;              // Count or stretch
    logic              stretch;              // Stretch this cycle
    logic              tick_d;               // Tick completes now

    // ****************************************
    // Address decode
    // ****************************************
    // True when the bus address names the given register
    function automatic logic addr_hit(input logic [`RFP_ADDR_W-1:0] addr,
                                      input logic [`RFP_ADDR_W-1:0] offset);
        return (addr == offset);
    endfunction : addr_hit

    // Register writes
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prescale_integer_q  <= `RFP_INT_RST;
            prescale_fraction_q <= `RFP_FRAC_RST;
        end
        else if (reg_wr)
        begin
            if (addr_hit(reg_addr, `RFP_OFF_INT))
            begin
                prescale_integer_q <= reg_wdata[INT_W-1:0];
            end
            if (addr_hit(reg_addr, `RFP_OFF_FRAC))
            begin
                prescale_fraction_q <= reg_wdata[FRAC_W-1:0];
            end
        end
    end

    // Read data one cycle after strobe, unmapped reads zero
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_rdata <= '0;
        end
        else if (reg_rd)
        begin
            if (addr_hit(reg_addr, `RFP_OFF_INT))
            begin
                reg_rdata <= {{(32-INT_W){1'b0}}, prescale_integer_q};
            end
            else if (addr_hit(reg_addr, `RFP_OFF_FRAC))
            begin
                reg_rdata <= {{(32-FRAC_W){1'b0}}, prescale_fraction_q};
            end
            else
            begin
                reg_rdata <= '0;
            end
        end
        else
        begin
            reg_rdata <= '0;
        end
    end

    // ****************************************
    // Divider
    // ****************************************
    rfp_stretch_match #(.FRAC_W(FRAC_W)) u_match
    (
        .frac_value (prescale_fraction_q),
        .frac_count (frac_count_q),
        .stretch    (stretch)
    );

    // Tick completes at count zero, unless a stretch clock is owed
    assign tick_d = (phase_q == RFP_STRETCH) ||
                    ((int_count_q == '0) && !stretch);

    // Integer counter and phase; runs only on clk edges
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            int_count_q <= '0;
            phase_q     <= RFP_COUNT;
        end
        else if (tick_d)
        begin
            int_count_q <= prescale_integer_q;
            phase_q     <= RFP_COUNT;
        end
        else if (int_count_q == '0)
        begin
            phase_q <= RFP_STRETCH;
        end
        else
        begin
            int_count_q <= int_count_q - 1'b1;
        end
    end

    // Fraction counter advances per tick, wrapping
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            frac_count_q <= '0;
        end
        else if (tick_d)
        begin
            frac_count_q <= frac_count_q + 1'b1;
        end
    end

    // Registered tick pulse
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ref_tick <= 1'b0;
        end
        else
        begin
            ref_tick <= tick_d;
        end
    end

    // Clock tick counter, one-second enable on wrap
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tick_count_q <= '0;
        end
        else if (ref_tick)
        begin
            tick_count_q <= tick_count_q + 1'b1;
        end
    end

    assign sec_tick = ref_tick && (&tick_count_q);

    rfp_seconds u_sec
    (
        .clk       (clk),
        .rst_b     (rst_b),
        .sec_en    (sec_tick),
        .seconds_q (seconds),
        .min_en    (min_en)
    );

    // ****************************************
    // Checks
    // ****************************************
    AST_TICK_RELOAD: assert property (@(posedge clk) disable iff (!rst_b)
        tick_d |=> int_count_q == $past(prescale_integer_q))
        else $error("integer counter not reloaded");
    AST_FRAC_ADV: assert property (@(posedge clk) disable iff (!rst_b)
        tick_d |=> frac_count_q == $past(frac_count_q) + 15'h0001)
        else $error("fraction counter did not advance");
    AST_HOLD_FRAC: assert property (@(posedge clk) disable iff (!rst_b)
        !tick_d |=> $stable(frac_count_q))
        else $error("fraction counter moved without tick");
    AST_STRETCH_ONE: assert property (@(posedge clk) disable iff (!rst_b)
        phase_q == RFP_STRETCH |=> phase_q == RFP_COUNT)
        else $error("stretch longer than one clock");
    // Stretch entry is decided on the fraction seen one edge earlier
    AST_NO_STRETCH_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
        $past(prescale_fraction_q) == '0 |-> phase_q == RFP_COUNT)
        else $error("stretch with zero fraction");
    AST_BIT14: assert property (@(posedge clk) disable iff (!rst_b)
        prescale_fraction_q[FRAC_W-1] && frac_count_q[0] |-> stretch)
        else $error("bit 14 stretch missing");
    AST_BIT13: assert property (@(posedge clk) disable iff (!rst_b)
        frac_count_q[1:0] == 2'h2 |-> stretch == prescale_fraction_q[FRAC_W-2])
        else $error("bit 13 match wrong");
    AST_SEC_EN: assert property (@(posedge clk) disable iff (!rst_b)
        sec_tick |=> tick_count_q == '0)
        else $error("second enable not at wrap");
    AST_RD_INT: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == `RFP_OFF_INT |=> reg_rdata[31:INT_W] == '0)
        else $error("integer reserved bits nonzero");

    COV_TICK: cover property (@(posedge clk) disable iff (!rst_b) ref_tick);
    COV_STRETCH: cover property (@(posedge clk) disable iff (!rst_b)
        phase_q == RFP_STRETCH);
    COV_SEC: cover property (@(posedge clk) disable iff (!rst_b) sec_tick);
    COV_RD_INT: cover property (@(posedge clk) disable iff (!rst_b)
        reg_rd && addr_hit(reg_addr, `RFP_OFF_INT));

    // ****************************************
    // Register port checks
    // ****************************************
    // Integer write lands one edge later
    AST_INT_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
        reg_wr && addr_hit(reg_addr, `RFP_OFF_INT) |=>
        prescale_integer_q == $past(reg_wdata[INT_W-1:0]))
        else $error("integer register write lost");
    // Fraction write lands one edge later
    AST_FRAC_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
        reg_wr && addr_hit(reg_addr, `RFP_OFF_FRAC) |=>
        prescale_fraction_q == $past(reg_wdata[FRAC_W-1:0]))
        else $error("fraction register write lost");
    // Integer register holds without its write
    AST_INT_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        !(reg_wr && addr_hit(reg_addr, `RFP_OFF_INT)) |=> $stable(prescale_integer_q))
        else $error("integer register changed unwritten");
    // Fraction register holds without its write
    AST_FRAC_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        !(reg_wr && addr_hit(reg_addr, `RFP_OFF_FRAC)) |=> $stable(prescale_fraction_q))
        else $error("fraction register changed unwritten");
    // Fraction reserved bits read zero
    AST_RD_FRAC: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rd && addr_hit(reg_addr, `RFP_OFF_FRAC) |=> reg_rdata[31:FRAC_W] == '0)
        else $error("fraction reserved bit nonzero");
    // Integer read returns the stored value
    AST_RD_INT_VAL: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rd && addr_hit(reg_addr, `RFP_OFF_INT) |=>
        reg_rdata[INT_W-1:0] == $past(prescale_integer_q))
        else $error("integer read value wrong");
    // Fraction read returns the stored value
    AST_RD_FRAC_VAL: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rd && addr_hit(reg_addr, `RFP_OFF_FRAC) |=>
        reg_rdata[FRAC_W-1:0] == $past(prescale_fraction_q))
        else $error("fraction read value wrong");
    // Read data is zero outside its one cycle
    AST_RD_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
        !reg_rd |=> reg_rdata == '0)
        else $error("read data outside its cycle");
    // Unmapped reads return zero
    AST_RD_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rd && !addr_hit(reg_addr, `RFP_OFF_INT) && !addr_hit(reg_addr, `RFP_OFF_FRAC)
        |=> reg_rdata == '0)
        else $error("unmapped read nonzero");

    // ****************************************
    // Divider checks
    // ****************************************
    // Counting down one per clock mid period
    AST_COUNT_DOWN: assert property (@(posedge clk) disable iff (!rst_b)
        phase_q == RFP_COUNT && int_count_q != '0 |=>
        int_count_q == $past(int_count_q) - 1'b1)
        else $error("integer counter did not count down");
    // No tick in the middle of a period
    AST_NO_TICK_MID: assert property (@(posedge clk) disable iff (!rst_b)
        phase_q == RFP_COUNT && int_count_q != '0 |-> !tick_d)
        else $error("tick in mid period");
    // An owed stretch enters the extra clock
    AST_ENTER_STRETCH: assert property (@(posedge clk) disable iff (!rst_b)
        phase_q == RFP_COUNT && int_count_q == '0 && stretch |=> phase_q == RFP_STRETCH)
        else $error("stretch clock not inserted");
    // The extra clock sits at count zero and ends the period
    AST_STRETCH_END: assert property (@(posedge clk) disable iff (!rst_b)
        phase_q == RFP_STRETCH |-> int_count_q == '0 && tick_d)
        else $error("stretch clock misplaced");
    // Fraction count zero never stretches
    AST_ZERO_COUNT: assert property (@(posedge clk) disable iff (!rst_b)
        frac_count_q == '0 |-> !stretch)
        else $error("stretch at fraction count zero");
    // Bit 12 matches counts ending in binary 100
    AST_BIT12: assert property (@(posedge clk) disable iff (!rst_b)
        frac_count_q[2:0] == 3'h4 |-> stretch == prescale_fraction_q[FRAC_W-3])
        else $error("bit 12 match wrong");
    // Fraction counter wraps at its width
    AST_FRAC_WRAP: assert property (@(posedge clk) disable iff (!rst_b)
        tick_d && (&frac_count_q) |=> frac_count_q == '0)
        else $error("fraction counter did not wrap");

    // ****************************************
    // Tick and time checks
    // ****************************************
    // Output tick follows the period end by one clock
    AST_TICK_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
        1'b1 |=> ref_tick == $past(tick_d))
        else $error("tick pulse misplaced");
    // Tick counter counts each tick
    AST_TICK_CNT: assert property (@(posedge clk) disable iff (!rst_b)
        ref_tick |=> tick_count_q == $past(tick_count_q) + 15'h0001)
        else $error("tick counter missed a tick");
    // Second enable only at the last tick
    AST_SEC_ONLY_WRAP: assert property (@(posedge clk) disable iff (!rst_b)
        sec_tick |-> (&tick_count_q))
        else $error("second enable early");
    // Minutes enable only with a second at 59
    AST_MIN_EN: assert property (@(posedge clk) disable iff (!rst_b)
        min_en |-> sec_tick && seconds == `RFP_SEC_MAX)
        else $error("minutes enable misplaced");
endmodule : rfp_prescaler

// file: rtl/rfp_seconds.sv
`timescale 1ns/100ps
`include "rfp_params.svh"
// ****************************************
// Seconds counter
// ****************************************
module rfp_seconds
    import rfp_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // Enable
    input  wire logic                  sec_en,
    // Outputs
    output logic [`RFP_SEC_W-1:0]      seconds_q,
    output logic                       min_en
);
    // Count 0..59 and wrap
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            seconds_q <= '0;
        end
        else if (sec_en)
        begin
            seconds_q <= (seconds_q == `RFP_SEC_MAX) ? '0 : seconds_q + 6'h01;
        end
    end

    // Minutes enable on wrap
    assign min_en = sec_en && (seconds_q == `RFP_SEC_MAX);

    AST_SEC_WRAP: assert property (@(posedge clk) disable iff (!rst_b)
        sec_en && seconds_q == `RFP_SEC_MAX |=> seconds_q == 6'h00)
        else $error("seconds did not wrap");
endmodule : rfp_seconds

// file: rtl/rfp_stretch_match.sv
`timescale 1ns/100ps
`include "rfp_params.svh"
// ****************************************
// Stretch decision from fraction counter
// ****************************************
module rfp_stretch_match
    import rfp_pkg::*;
#(
    parameter int FRAC_W = `RFP_FRAC_W
)
(
    // Inputs
    input  wire logic [FRAC_W-1:0] frac_value,
    input  wire logic [FRAC_W-1:0] frac_count,
    // Result
    output logic                   stretch
);
    logic                          lower_zero;  // No set bit below position j yet

    // Lowest set bit at position j selects fraction bit FRAC_W-1-j
    always_comb
    begin
        stretch    = 1'b0;
        lower_zero = 1'b1;
        for (int j = 0; j < FRAC_W; j++)
        begin
            if (frac_count[j] && lower_zero)
            begin
                stretch = frac_value[FRAC_W-1-j];
            end
            if (frac_count[j])
            begin
                lower_zero = 1'b0;
            end
        end
    end
endmodule : rfp_stretch_match

// file: testbench/rfp_tick_sink.sv
`timescale 1ns/100ps
// ****************************************
// Far side: clock tick counter model
// ****************************************
module rfp_tick_sink
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Divider tick in
    input  wire logic        ref_tick,
    // Expected one-second enable
    output logic             sec_exp
);
    logic [14:0]             ticks_q;   // Ticks seen this second

    // Count every divider tick, wrap at 32768
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ticks_q <= 15'h0000;
        else if (ref_tick)
            ticks_q <= ticks_q + 15'h0001;
    end

    // Enable on the last tick of each second
    assign sec_exp = ref_tick && (ticks_q == 15'h7fff);
endmodule : rfp_tick_sink

// file: testbench/test_rfp_prescaler.sv
`timescale 1ns/100ps
`include "rfp_params.svh"
// ****************************************
// Prescaler bench
// ****************************************
module test_rfp_prescaler;
    logic        clk = 1'b0;      // 40 MHz clock
    logic        rst_b = 1'b0;    // Reset, active low
    logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata;
    logic        reg_wr = 1'b0, reg_rd = 1'b0;
    logic        ref_tick, sec_tick, min_en, sec_exp;
    logic [14:0] tick_count_q;    // Design tick counter
    logic [5:0]  seconds;         // Design seconds
    int          failures = 0;    // Mismatches
    int          checked = 0;     // Comparisons

    always #12.5 clk = ~clk;

    rfp_prescaler i_rfp_prescaler (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ref_tick(ref_tick), .sec_tick(sec_tick), .tick_count_q(tick_count_q),
        .seconds(seconds), .min_en(min_en));
    rfp_tick_sink i_rfp_tick_sink (.clk(clk), .rst_b(rst_b), .ref_tick(ref_tick),
        .sec_exp(sec_exp));

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One write cycle
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // One read cycle, data judged in the following cycle
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, exp);
    endtask : rd

    // Clocks up to and including the next tick
    task automatic wait_tick(output int c);
        c = 0;
        do
        begin
            @(negedge clk);
            c++;
        end
        while (ref_tick !== 1'b1 && c < 20000);
    endtask : wait_tick

    // Total clocks over n periods, after syncing
    task automatic measure(input int n, output int clks);
        int c;
        clks = 0;
        wait_tick(c);
        wait_tick(c);
        repeat (n)
        begin
            wait_tick(c);
            clks += c;
        end
    endtask : measure

    // Reset values, masking, unmapped place
    task automatic t_regs;
        rd(`RFP_OFF_INT, 32'h0);
        rd(`RFP_OFF_FRAC, 32'h0);
        wr(`RFP_OFF_INT, 32'hffffffff);
        wr(`RFP_OFF_FRAC, 32'hffffffff);
        wr(32'he0024088, 32'h00000000);
        rd(`RFP_OFF_INT, 32'h1fff);
        rd(`RFP_OFF_FRAC, 32'h7fff);
        rd(32'he0024088, 32'h0);
    endtask : t_regs

    // Period lengths for single and combined fraction bits
    task automatic t_periods;
        logic [31:0] fr [7] = '{32'h0, 32'h4000, 32'h2000, 32'h1000, 32'h0800, 32'h0400,
                                 32'h7c00};
        int          st [7] = '{0, 16, 8, 4, 2, 1, 31};
        int          c;
        wr(`RFP_OFF_INT, 32'h3);
        for (int i = 0; i < 7; i++)
        begin
            wr(`RFP_OFF_FRAC, fr[i]);
            measure(32, c);
            chk(32'(c), 32'(32 * 4 + st[i]));
        end
    endtask : t_periods

    // Shortest period, run to one second
    task automatic t_second;
        int g;
        wr(`RFP_OFF_INT, 32'h0);
        wr(`RFP_OFF_FRAC, 32'h0);
        for (g = 0; g < 40000; g++)
        begin
            @(negedge clk);
            if (sec_tick === 1'b1 || sec_exp === 1'b1)
                break;
        end
        chk({31'h0, sec_tick}, {31'h0, sec_exp});
        chk({31'h0, min_en}, 32'h0);
        chk({17'h0, tick_count_q}, 32'h7fff);
        @(negedge clk);
        chk({26'h0, seconds}, 32'h1);
    endtask : t_second

    // Verdict and end of run
    task automatic results;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_periods();
        t_second();
        results();
    end

    // Hang guard
    initial
    begin
        #(25 * 60000);
        failures++;
        results();
    end
endmodule : test_rfp_prescaler
